// *** src/mrs_pkg.sv ***
// Constants for the modem reset and event status register bank.
package mrs_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] OFS_SOFT_RESET = 6'h07;
   localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 6'h20;
   localparam logic [DATA_W-1:0] SOFT_RESET_RST = 16'h0000;
   localparam logic [DATA_W-1:0] EVENT_FLAGS_RST = 16'h0000;
   localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
   localparam logic [DATA_W-1:0] SOFT_RESET_WMASK = 16'hFFFE;
   localparam int SOFT_RESET_BIT = 0;
   localparam int BIT_RESET_SEEN = 15;
   localparam int BIT_TALK_EXPIRED = 14;
   localparam int BIT_TALK_TRIGGERED = 13;
   localparam int BIT_GAP_ERR = 12;
   localparam int BIT_FRAME_ERR = 11;
   localparam int BIT_PARITY_ERR = 10;
   localparam int BIT_HOST_TIMEOUT = 9;
   localparam int BIT_CHECKSUM_ERR = 8;
   localparam int BIT_RX_THRESH = 7;
   localparam int BIT_RX_FULL = 6;
   localparam int BIT_RX_EMPTY = 5;
   localparam int BIT_TX_THRESH = 4;
   localparam int BIT_TX_FULL = 3;
   localparam int BIT_TX_EMPTY = 2;
   localparam int BIT_CARRIER = 1;
   localparam int BIT_CLEAR_TO_SEND = 0;
   localparam logic [DATA_W-1:0] LATCH_MASK = 16'h9F00;
endpackage : mrs_pkg

// *** src/mrs_regs.sv ***
// Software reset register and modem event status register.
`timescale 1ns/100ps
module mrs_regs
   import mrs_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_carrier_present,
   input wire logic i_send_request,
   input wire logic i_full_duplex,
   input wire logic i_rx_queue_at_threshold,
   input wire logic i_rx_queue_full,
   input wire logic i_rx_queue_empty,
   input wire logic i_tx_queue_at_threshold,
   input wire logic i_tx_queue_full,
   input wire logic i_tx_queue_empty,
   input wire logic i_talk_limit_expired,
   input wire logic i_talk_limit_triggered,
   input wire logic i_gap_error,
   input wire logic i_frame_error,
   input wire logic i_parity_error,
   input wire logic i_host_timeout_expired,
   input wire logic i_checksum_error,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_rd_valid,
   output logic o_soft_reset,
   output logic o_fifo_flush,
   output logic [DATA_W-1:0] o_event_flags,
   output logic o_clear_to_send
);
   logic [DATA_W-1:0] flags_q;
   logic [DATA_W-1:0] flags_d;
   logic [DATA_W-1:0] rsv_q;
   logic [DATA_W-1:0] rsv_d;
   logic soft_q;
   logic [DATA_W-1:0] rdata_q;
   logic rd_valid_q;
   localparam logic [DATA_W-1:0] SEEN_MASK = DATA_W'(1) << BIT_RESET_SEEN;

   wire sel_reset = (i_addr == OFS_SOFT_RESET);
   wire sel_flags = (i_addr == OFS_EVENT_FLAGS);
   wire wr_reset = i_wr_en & sel_reset;
   wire wr_flags = i_wr_en & sel_flags;
   wire soft_hit = wr_reset & i_wdata[SOFT_RESET_BIT];
   // Live bits; carrier and clear-to-send never see host write data.
   wire cts_live = i_send_request & (i_full_duplex | ~i_carrier_present);
   logic [DATA_W-1:0] live_vec;
   logic [DATA_W-1:0] event_vec;
   always_comb begin
      live_vec = ZERO_WORD;
      live_vec[BIT_TALK_EXPIRED] = i_talk_limit_expired;
      live_vec[BIT_TALK_TRIGGERED] = i_talk_limit_triggered;
      live_vec[BIT_RX_THRESH] = i_rx_queue_at_threshold;
      live_vec[BIT_RX_FULL] = i_rx_queue_full;
      live_vec[BIT_RX_EMPTY] = i_rx_queue_empty;
      live_vec[BIT_TX_THRESH] = i_tx_queue_at_threshold;
      live_vec[BIT_TX_FULL] = i_tx_queue_full;
      live_vec[BIT_TX_EMPTY] = i_tx_queue_empty;
      live_vec[BIT_CARRIER] = i_carrier_present;
      live_vec[BIT_CLEAR_TO_SEND] = cts_live;
      event_vec = ZERO_WORD;
      event_vec[BIT_RESET_SEEN] = soft_q;
      event_vec[BIT_GAP_ERR] = i_gap_error;
      event_vec[BIT_FRAME_ERR] = i_frame_error;
      event_vec[BIT_PARITY_ERR] = i_parity_error;
      event_vec[BIT_HOST_TIMEOUT] = i_host_timeout_expired;
      event_vec[BIT_CHECKSUM_ERR] = i_checksum_error;
   end
   // A new event wins over a clear or a soft reset in the same cycle, so no event is lost.
   wire [DATA_W-1:0] w1c_vec = wr_flags ? i_wdata : ZERO_WORD;
   wire [DATA_W-1:0] keep_vec = soft_q ? ZERO_WORD : (flags_q & ~w1c_vec);
   assign flags_d = (((keep_vec | event_vec) & LATCH_MASK) | (live_vec & ~LATCH_MASK));
   assign rsv_d = soft_q ? SOFT_RESET_RST : (wr_reset ? (i_wdata & SOFT_RESET_WMASK) : rsv_q);
   wire [DATA_W-1:0] rd_mux = sel_reset ? rsv_q : (sel_flags ? flags_q : ZERO_WORD);

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         flags_q <= EVENT_FLAGS_RST;
         rsv_q <= SOFT_RESET_RST;
         soft_q <= 1'b0;
         rdata_q <= ZERO_WORD;
         rd_valid_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         rsv_q <= rsv_d;
         soft_q <= soft_hit;
         rdata_q <= i_rd_en ? rd_mux : rdata_q;
         rd_valid_q <= i_rd_en;
      end
   end

   assign o_rdata = rdata_q;
   assign o_rd_valid = rd_valid_q;
   assign o_soft_reset = soft_q;
   assign o_fifo_flush = soft_q;
   assign o_event_flags = flags_q;
   assign o_clear_to_send = flags_q[BIT_CLEAR_TO_SEND];

   sequence s_soft_write;
      i_wr_en && sel_reset && i_wdata[SOFT_RESET_BIT];
   endsequence
   sequence s_flush_pulse;
      o_soft_reset && o_fifo_flush ##1 !o_soft_reset;
   endsequence

   soft_reset_pulse_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      s_soft_write ##1 !(i_wr_en && sel_reset && i_wdata[SOFT_RESET_BIT]) |-> s_flush_pulse)
      else $error("soft reset did not pulse for one cycle");
   soft_reset_clears_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_soft_reset |=> ((o_event_flags & LATCH_MASK & ~SEEN_MASK) == ($past(event_vec) & LATCH_MASK & ~SEEN_MASK)))
      else $error("latched flags survived a soft reset");
   reset_bit_zero_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_rd_en && sel_reset |=> o_rd_valid && !o_rdata[SOFT_RESET_BIT])
      else $error("write-only reset bit read back as one");
   sticky_hold_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_event_flags[BIT_GAP_ERR] && !(i_wr_en && sel_flags && i_wdata[BIT_GAP_ERR]) && !o_soft_reset
      |=> o_event_flags[BIT_GAP_ERR])
      else $error("sticky gap flag dropped without a clear");
   w1c_clear_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_wr_en && sel_flags && i_wdata[BIT_CHECKSUM_ERR] && !i_checksum_error |=> !o_event_flags[BIT_CHECKSUM_ERR])
      else $error("checksum flag not cleared by write of one");
   event_set_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_checksum_error |=> o_event_flags[BIT_CHECKSUM_ERR] [*1] ##0 $past(i_checksum_error))
      else $error("checksum event did not set its flag");
   carrier_live_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_CARRIER] == $past(i_carrier_present))
      else $error("carrier bit does not follow the carrier");
   cts_gate_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      !i_full_duplex && (i_carrier_present || !i_send_request) |=> !o_clear_to_send)
      else $error("clear-to-send raised while blocked");
   talk_live_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      $fell(i_talk_limit_triggered) |=> !o_event_flags[BIT_TALK_TRIGGERED])
      else $error("talk-limit flag latched");

   // Both registers must come back to their defaults after i_reset; a soft reset clears the reset register and latched flags and sets reset-seen.
   reset_defaults_a : assert property (@(posedge i_ref_clk)
      i_reset |=> o_event_flags == EVENT_FLAGS_RST && rsv_q == SOFT_RESET_RST && !o_soft_reset && !o_rd_valid)
      else $error("registers not at defaults after reset");
   soft_reg_clear_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_soft_reset |=> rsv_q == SOFT_RESET_RST)
      else $error("reset register kept its bits through a soft reset");
   seen_set_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_soft_reset |=> o_event_flags[BIT_RESET_SEEN])
      else $error("reset-seen flag not set after a soft reset");
   sequence s_flags_read;
      i_rd_en && sel_flags;
   endsequence
   sequence s_other_read;
      i_rd_en && !sel_flags && !sel_reset;
   endsequence
   flags_read_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      s_flags_read |=> o_rd_valid && o_rdata == $past(o_event_flags))
      else $error("flag read returned a stale word");
   reserved_read_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_rd_en && sel_reset |=> o_rd_valid && o_rdata == $past(rsv_q))
      else $error("reset register read back wrong");
   unmapped_read_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      s_other_read |=> o_rd_valid && o_rdata == ZERO_WORD)
      else $error("unmapped offset read back nonzero");
   // Every flag is registered, so live bits are held against their pins one cycle back.
   event_wins_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> (o_event_flags & $past(event_vec)) == $past(event_vec))
      else $error("an event was lost to a clear or a soft reset");
   live_track_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> (o_event_flags & ~LATCH_MASK) == ($past(live_vec) & ~LATCH_MASK))
      else $error("a live bit latched or took host data");
   rx_thresh_live_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_RX_THRESH] == $past(i_rx_queue_at_threshold))
      else $error("receive threshold bit does not follow its queue");
   rx_full_live_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_RX_FULL] == $past(i_rx_queue_full))
      else $error("receive full bit does not follow its queue");
   rx_empty_live_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_RX_EMPTY] == $past(i_rx_queue_empty))
      else $error("receive empty bit does not follow its queue");
   tx_thresh_live_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_TX_THRESH] == $past(i_tx_queue_at_threshold))
      else $error("transmit threshold bit does not follow its queue");
   tx_full_live_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_TX_FULL] == $past(i_tx_queue_full))
      else $error("transmit full bit does not follow its queue");
   tx_empty_live_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_TX_EMPTY] == $past(i_tx_queue_empty))
      else $error("transmit empty bit does not follow its queue");
   talk_expired_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_TALK_EXPIRED] == $past(i_talk_limit_expired))
      else $error("talk-limit expired bit does not follow the inhibitor");
   talk_trig_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> o_event_flags[BIT_TALK_TRIGGERED] == $past(i_talk_limit_triggered))
      else $error("talk-limit triggered bit does not follow the inhibitor");
   cts_open_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_send_request && (i_full_duplex || !i_carrier_present) |=> o_clear_to_send && o_event_flags[BIT_CLEAR_TO_SEND])
      else $error("clear-to-send held low while allowed");
   gap_set_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_gap_error |=> o_event_flags[BIT_GAP_ERR])
      else $error("gap event did not set its flag");
   frame_set_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_frame_error |=> o_event_flags[BIT_FRAME_ERR])
      else $error("frame event did not set its flag");
   parity_set_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_parity_error |=> o_event_flags[BIT_PARITY_ERR])
      else $error("parity event did not set its flag");
   timeout_set_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_host_timeout_expired |=> o_event_flags[BIT_HOST_TIMEOUT])
      else $error("host timeout event did not set its flag");
   frame_hold_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_event_flags[BIT_FRAME_ERR] && !(i_wr_en && sel_flags && i_wdata[BIT_FRAME_ERR]) && !o_soft_reset
      |=> o_event_flags[BIT_FRAME_ERR])
      else $error("sticky frame flag dropped without a clear");
   parity_hold_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_event_flags[BIT_PARITY_ERR] && !(i_wr_en && sel_flags && i_wdata[BIT_PARITY_ERR]) && !o_soft_reset
      |=> o_event_flags[BIT_PARITY_ERR])
      else $error("sticky parity flag dropped without a clear");
   timeout_hold_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_event_flags[BIT_HOST_TIMEOUT] && !(i_wr_en && sel_flags && i_wdata[BIT_HOST_TIMEOUT]) && !o_soft_reset
      |=> o_event_flags[BIT_HOST_TIMEOUT])
      else $error("sticky timeout flag dropped without a clear");
   checksum_hold_a : assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_event_flags[BIT_CHECKSUM_ERR] && !(i_wr_en && sel_flags && i_wdata[BIT_CHECKSUM_ERR]) && !o_soft_reset
      |=> o_event_flags[BIT_CHECKSUM_ERR])
      else $error("sticky checksum flag dropped without a clear");
endmodule : mrs_regs

// *** verif/mrs_host_model.sv ***
// Host controller model driving the register strobe port.
`timescale 1ns/100ps
module mrs_host_model
   import mrs_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rd_valid,
   input wire logic [DATA_W-1:0] i_rdata,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_wdata
);
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 6'h00;
      o_wdata = 16'h0000;
   end
   // A released bus shows the inverse, so a stale word can never pass for a fresh one.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge i_ref_clk);
      o_wr_en = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_ref_clk);
      o_wr_en = 1'b0;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(negedge i_ref_clk);
      o_rd_en = 1'b1;
      o_addr = a;
      @(negedge i_ref_clk);
      d = i_rd_valid ? i_rdata : ~i_rdata;
      o_rd_en = 1'b0;
      o_addr = ~o_addr;
   endtask : rd
endmodule : mrs_host_model

// *** verif/mrs_regs_tb.sv ***
// Self-checking testbench for the modem reset and event status registers.
`timescale 1ns/100ps
module mrs_regs_tb
   import mrs_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, wr, rdn, rv, sr, ff, cts, req = 1'b0, dup = 1'b0;
   logic [ADDR_W-1:0] a;
   logic [DATA_W-1:0] wd, rdt, fl, d, stim = 16'h0000;
   int err_count = 0, check_count = 0, cyc = 0;
   always #2 clk = ~clk;
   mrs_host_model host (.i_ref_clk(clk), .i_rd_valid(rv), .i_rdata(rdt), .o_wr_en(wr), .o_rd_en(rdn),
      .o_addr(a), .o_wdata(wd));
   mrs_regs DUT (.i_ref_clk(clk), .i_reset(rst), .i_wr_en(wr), .i_rd_en(rdn), .i_addr(a), .i_wdata(wd),
      .i_carrier_present(stim[1]), .i_send_request(req), .i_full_duplex(dup),
      .i_rx_queue_at_threshold(stim[7]), .i_rx_queue_full(stim[6]), .i_rx_queue_empty(stim[5]),
      .i_tx_queue_at_threshold(stim[4]), .i_tx_queue_full(stim[3]), .i_tx_queue_empty(stim[2]),
      .i_talk_limit_expired(stim[14]), .i_talk_limit_triggered(stim[13]), .i_gap_error(stim[12]),
      .i_frame_error(stim[11]), .i_parity_error(stim[10]), .i_host_timeout_expired(stim[9]),
      .i_checksum_error(stim[8]), .o_rdata(rdt), .o_rd_valid(rv), .o_soft_reset(sr), .o_fifo_flush(ff),
      .o_event_flags(fl), .o_clear_to_send(cts));
   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_count++;
         close_out();
      end
   end
   task automatic t_events();
      @(negedge clk) stim = 16'h1F00;
      @(negedge clk) stim = 16'h0000;
      host.rd(OFS_EVENT_FLAGS, d); chk(d, 16'h1F00);
      host.wr(OFS_EVENT_FLAGS, 16'h0000); host.rd(OFS_EVENT_FLAGS, d); chk(d, 16'h1F00);
      host.wr(OFS_EVENT_FLAGS, 16'h0100); host.rd(OFS_EVENT_FLAGS, d); chk(d, 16'h1E00);
      host.wr(OFS_EVENT_FLAGS, 16'hFFFF); chk(fl, 16'h0000);
      $display("events done");
   endtask : t_events
   task automatic t_live();
      @(negedge clk) stim = 16'h60FE;
      @(negedge clk) chk(fl, 16'h60FE);
      host.wr(OFS_EVENT_FLAGS, 16'hFFFF); chk(fl, 16'h60FE);
      @(negedge clk) stim = 16'h0000;
      @(negedge clk) chk(fl, 16'h0000);
      $display("live done");
   endtask : t_live
   task automatic t_cts();
      // Index bits are duplex, carrier and request; 8'hA2 marks the rows allowed to send.
      for (int i = 0; i < 8; i++) begin
         @(negedge clk) {dup, stim[1], req} = i[2:0];
         repeat (2) @(negedge clk);
         chk({15'h0000, cts}, {15'h0000, 1'(8'hA2 >> i)});
         chk(fl & 16'h0001, {15'h0000, 1'(8'hA2 >> i)});
      end
      @(negedge clk) {dup, stim[1], req} = 3'h0;
      $display("cts done");
   endtask : t_cts
   task automatic t_soft();
      host.wr(OFS_SOFT_RESET, 16'hFFFE); chk({14'h0000, sr, ff}, 16'h0000);
      host.rd(OFS_SOFT_RESET, d); chk(d, 16'hFFFE);
      @(negedge clk) stim = 16'h1F00;
      @(negedge clk) stim = 16'h0000;
      chk(fl, 16'h1F00);
      host.wr(OFS_SOFT_RESET, 16'h0001); chk({14'h0000, sr, ff}, 16'h0003);
      @(negedge clk) chk({14'h0000, sr, ff}, 16'h0000);
      chk(fl, 16'h8000);
      host.rd(OFS_SOFT_RESET, d); chk(d, 16'h0000);
      host.wr(OFS_EVENT_FLAGS, 16'h8000); chk(fl, 16'h0000);
      $display("soft reset done");
   endtask : t_soft
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      host.rd(OFS_SOFT_RESET, d); chk(d, SOFT_RESET_RST);
      host.rd(OFS_EVENT_FLAGS, d); chk(d, EVENT_FLAGS_RST);
      host.rd(6'h3F, d); chk(d, 16'h0000);
      $display("reset values done");
      t_events();
      t_live();
      t_cts();
      t_soft();
      close_out();
   end
endmodule : mrs_regs_tb
